// >>> hw/dmars_pkg.sv
// Purpose: Constants for the DMA channel request-select block
// Assumes: APB, 32-bit data, one aligned word per register
// Notes:   Named request sources sit at fixed select codes
// How it works
// - Force bit starts exactly one transfer
// - Writing zero to force does nothing
// - Channel disable clears the force bit
// - Low byte selects request; 08 timer3, 07 timer2
// - Select zero uses external interrupt zero
// - Select 0A uses serial interface one done
package dmars_pkg;
  localparam logic [11:0] DMARS_REQ_SEL_OFFSET    = 12'h000;
  localparam logic [11:0] DMARS_STATUS_OFFSET     = 12'h004;
  localparam int          DMARS_FORCE_BIT         = 15;
  localparam int          DMARS_SEL_W             = 8;
  localparam int          DMARS_REQ_LINES         = 256;
  localparam logic [7:0]  DMARS_SEL_RESET         = 8'h00;
  localparam logic [7:0]  DMARS_SEL_EXT_ZERO      = 8'h00;
  localparam logic [7:0]  DMARS_SEL_TIMER_TWO     = 8'h07;
  localparam logic [7:0]  DMARS_SEL_TIMER_THREE   = 8'h08;
  localparam logic [7:0]  DMARS_SEL_SERIAL_ONE    = 8'h0A;
  localparam logic [7:0]  DMARS_SEL_CONVERTER_ONE = 8'h0D;
  typedef enum logic [1:0] {DMARS_IDLE, DMARS_BUSY} dmars_state_type;
endpackage

// >>> hw/dmars_req_mux.sv
// Purpose: Picks one peripheral request line by index
// Assumes: Request lines are synchronous one-cycle pulses
// Notes:   Named sources sit at their select codes in the vector
`timescale 1ns/1ns
`default_nettype none
module dmars_req_mux
  import dmars_pkg::*;
#(
  parameter int LINES = DMARS_REQ_LINES
) (
  input  wire logic [LINES-1:0] req_lines,
  input  wire logic [7:0]       sel,
  output logic                  req_out
);
  always_comb begin
    req_out = req_lines[sel];
  end
endmodule
`default_nettype wire

// >>> hw/dmars_top.sv
// Purpose: Request select and manual force for one DMA channel
// Assumes: APB slave, one clock, peripheral requests synchronous to pclk
// Notes:   Transfer engine answers each start with one done pulse
`timescale 1ns/1ns
`default_nettype none
module dmars_top
  import dmars_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        channel_enable,
  input  wire logic        external_interrupt_zero,
  input  wire logic        timer_two_request,
  input  wire logic        timer_three_request,
  input  wire logic        serial_iface_one_done,
  input  wire logic        converter_one_done,
  input  wire logic [255:0] other_requests,
  input  wire logic        transfer_done,
  output logic             transfer_start,
  output logic             transfer_forced
);
  logic [7:0]      sel_q, sel_d;
  logic            force_q, force_d;
  logic            busy_forced_q, busy_forced_d;
  dmars_state_type state_q, state_d;
  logic [31:0]     prdata_q, prdata_d;
  logic [255:0]    req_vec;
  logic            sel_req;
  logic            wr_en, rd_en, hit_sel, hit_sts;

  // Address compare shared by the two register decodes
  function automatic logic addr_is(input logic [11:0] addr, input logic [11:0] offset);
    return addr == offset;
  endfunction

  // Named sources override the generic vector at their codes
  always_comb begin
    req_vec                          = other_requests;
    req_vec[DMARS_SEL_EXT_ZERO]      = external_interrupt_zero;
    req_vec[DMARS_SEL_TIMER_TWO]     = timer_two_request;
    req_vec[DMARS_SEL_TIMER_THREE]   = timer_three_request;
    req_vec[DMARS_SEL_SERIAL_ONE]    = serial_iface_one_done;
    req_vec[DMARS_SEL_CONVERTER_ONE] = converter_one_done;
  end

  dmars_req_mux #(.LINES(DMARS_REQ_LINES)) u_mux (
    .req_lines (req_vec),
    .sel       (sel_q),
    .req_out   (sel_req)
  );

  assign pready  = 1'b1;
  assign hit_sel = addr_is(paddr, DMARS_REQ_SEL_OFFSET);
  assign hit_sts = addr_is(paddr, DMARS_STATUS_OFFSET);
  assign wr_en   = psel & penable & pwrite & clk_en;
  // Reads are captured at the end of setup so the word stands through the zero-wait access;
  // the status read back is therefore one cycle old
  assign rd_en   = psel & ~penable & ~pwrite;
  assign pslverr = psel & penable & ~(hit_sel | hit_sts);
  assign prdata  = prdata_q;

  // Start while idle and enabled; force outranks the peripheral request
  assign transfer_start  = clk_en & channel_enable & (state_q == DMARS_IDLE)
                           & (force_q | sel_req);
  assign transfer_forced = force_q;

  always_comb begin
    sel_d         = sel_q;
    force_d       = force_q;
    state_d       = state_q;
    busy_forced_d = busy_forced_q;
    prdata_d      = prdata_q;
    case (state_q)
      DMARS_IDLE: begin
        if (transfer_start) begin
          state_d       = DMARS_BUSY;
          busy_forced_d = force_q;
        end
      end
      DMARS_BUSY: begin
        if (transfer_done) begin
          state_d = DMARS_IDLE;
          // Only the transfer that the force bit launched may clear it
          if (busy_forced_q) begin
            force_d = 1'b0;
          end
          busy_forced_d = 1'b0;
        end
      end
      default: state_d = DMARS_IDLE;
    endcase
    if (wr_en && hit_sel) begin
      if (pstrb[0]) begin
        sel_d = pwdata[DMARS_SEL_W-1:0];
      end
      // A zero write leaves force alone; set wins over the done clear, but channel disable wins over set
      if (pstrb[1] && pwdata[DMARS_FORCE_BIT]) begin
        force_d = 1'b1;
      end
    end
    if (!channel_enable) begin
      // Disable drops any pending or running forced transfer
      force_d       = 1'b0;
      state_d       = DMARS_IDLE;
      busy_forced_d = 1'b0;
    end
    if (rd_en && hit_sel) begin
      prdata_d = {16'h0000, force_q, 7'h00, sel_q};
    end else if (rd_en && hit_sts) begin
      prdata_d = {30'h0, busy_forced_q, state_q == DMARS_BUSY};
    end else if (rd_en) begin
      prdata_d = 32'h00000000;
    end
  end

  // Read data is registered at the end of setup, so it is valid at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q         <= DMARS_SEL_RESET;
      force_q       <= 1'b0;
      state_q       <= DMARS_IDLE;
      busy_forced_q <= 1'b0;
      prdata_q      <= 32'h00000000;
    end else if (clk_en) begin
      sel_q         <= sel_d;
      force_q       <= force_d;
      state_q       <= state_d;
      busy_forced_q <= busy_forced_d;
      prdata_q      <= prdata_d;
    end
  end

  AST_FORCE_CLEARS_ON_DONE: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && busy_forced_q && transfer_done && state_q == DMARS_BUSY
    && !(wr_en && hit_sel && pwdata[DMARS_FORCE_BIT]) |=> !force_q)
    else $error("force bit not cleared after forced transfer");
  AST_FORCE_NOT_CLEARED_BY_SW: assert property (@(posedge pclk) disable iff (!presetn)
    force_q && channel_enable && !transfer_done |=> force_q)
    else $error("force bit cleared without done or disable");
  AST_DISABLE_CLEARS_FORCE: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !channel_enable |=> !force_q)
    else $error("force bit survives channel disable");
  AST_SEL_RESERVED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && hit_sel && clk_en |=> prdata[14:8] == 7'h00)
    else $error("reserved bits read nonzero");
  AST_START_FOLLOWS_SELECT: assert property (@(posedge pclk) disable iff (!presetn)
    transfer_start && !force_q |-> req_vec[sel_q])
    else $error("start without selected request");
  AST_EXT_ZERO_SELECT: assert property (@(posedge pclk) disable iff (!presetn)
    sel_q == DMARS_SEL_EXT_ZERO && !force_q && transfer_start |-> external_interrupt_zero)
    else $error("external interrupt zero select mismatch");
  AST_SPI_SELECT: assert property (@(posedge pclk) disable iff (!presetn)
    sel_q == DMARS_SEL_SERIAL_ONE && !force_q && transfer_start |-> serial_iface_one_done)
    else $error("spi select mismatch");
  AST_ADC_SELECT: assert property (@(posedge pclk) disable iff (!presetn)
    sel_q == DMARS_SEL_CONVERTER_ONE && !force_q && transfer_start |-> converter_one_done)
    else $error("adc select mismatch");
  AST_TIMER_TWO_SELECT: assert property (@(posedge pclk) disable iff (!presetn)
    sel_q == DMARS_SEL_TIMER_TWO && !force_q && transfer_start |-> timer_two_request)
    else $error("timer two select mismatch");
  AST_TIMER_THREE_SELECT: assert property (@(posedge pclk) disable iff (!presetn)
    sel_q == DMARS_SEL_TIMER_THREE && !force_q && transfer_start |-> timer_three_request)
    else $error("timer three select mismatch");
  AST_SEL_WRITE_LANDS: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr_en && hit_sel && pstrb[0] |=> sel_q == $past(pwdata[7:0]))
    else $error("select write did not land");

  // Named steps of a forced transfer: launch, busy, finish
  sequence forced_launch;
    clk_en && transfer_start && force_q;
  endsequence
  sequence forced_busy;
    state_q == DMARS_BUSY && busy_forced_q;
  endsequence
  sequence forced_finish;
    clk_en && channel_enable && busy_forced_q && transfer_done;
  endsequence

  AST_FORCED_LAUNCH_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
    forced_launch |=> forced_busy)
    else $error("forced launch did not enter busy");
  AST_FORCED_FINISH_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    forced_finish |=> state_q == DMARS_IDLE && !busy_forced_q)
    else $error("forced transfer did not finish");
  AST_NO_START_WHILE_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == DMARS_BUSY |-> !transfer_start)
    else $error("second start while busy");
  AST_FORCE_NEEDS_NO_REQUEST: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && channel_enable && force_q && state_q == DMARS_IDLE |-> transfer_start)
    else $error("force waited for a request");
  AST_ZERO_WRITE_KEEPS_FORCE: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr_en && hit_sel && !pwdata[DMARS_FORCE_BIT] && force_q && channel_enable
    && !(busy_forced_q && transfer_done) |=> force_q)
    else $error("zero write cleared force");
  AST_DISABLE_IDLES: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !channel_enable |=> state_q == DMARS_IDLE && !busy_forced_q)
    else $error("channel disable left transfer running");

  // Bus side and clock enable
  AST_STATUS_READ: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && rd_en && hit_sts |=> prdata == {30'h0, $past(busy_forced_q), $past(state_q) == DMARS_BUSY})
    else $error("status read mismatch");
  AST_UNMAPPED_READS_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && rd_en && !hit_sel && !hit_sts |=> prdata == 32'h00000000)
    else $error("unmapped read nonzero");
  AST_READY_ZERO_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable |-> pready)
    else $error("ready low in access");
  AST_FREEZE_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en |=> $stable(sel_q) && $stable(force_q) && $stable(state_q))
    else $error("state moved while clock enable low");
endmodule
`default_nettype wire

// >>> verification/dmars_engine_model.sv
// Purpose: Transfer engine stand-in that answers each start with one done pulse
// Assumes: lag sets how many extra cycles the engine takes
// Notes:   Starts seen while busy are ignored, as a real engine would
`timescale 1ns/1ns
`default_nettype none
module dmars_engine_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       transfer_start,
  input  wire logic [1:0] lag,
  output logic            transfer_done
);
  logic [2:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q         <= 3'h0;
      transfer_done <= 1'b0;
    end else begin
      transfer_done <= (cnt_q == 3'h1);
      if (cnt_q != 3'h0) begin
        cnt_q <= cnt_q - 3'h1;
      end else if (transfer_start && !transfer_done) begin
        cnt_q <= {1'b0, lag} + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/dmars_top_tb.sv
// Purpose: Self-checking bench for the request-select block
// Assumes: Zero-wait APB slave, read data valid at the access edge
// Notes:   Engine lags and one select code are random from a fixed seed
`timescale 1ns/1ns
`default_nettype none
module dmars_top_tb
  import dmars_pkg::*;
;
  logic         pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0;
  logic         penable = 1'b0, pwrite = 1'b0, channel_enable = 1'b1;
  logic         pready, pslverr, transfer_done, transfer_start, transfer_forced, err;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0, prdata, rd;
  logic [3:0]   pstrb = 4'hF;
  logic [4:0]   named = 5'h0, sel5;
  logic [1:0]   lag = 2'h0;
  logic [7:0]   code;
  logic [255:0] other_requests = '0;
  logic [7:0]   codes [5] = '{8'h00, 8'h07, 8'h08, 8'h0A, 8'h0D};
  int           bad_count = 0, tests_run = 0;
  wire logic    external_interrupt_zero, timer_two_request, timer_three_request;
  wire logic    serial_iface_one_done, converter_one_done;
  assign {converter_one_done, serial_iface_one_done, timer_three_request,
          timer_two_request, external_interrupt_zero} = named;
  always #4 pclk = ~pclk;
  dmars_top dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .channel_enable(channel_enable),
    .external_interrupt_zero(external_interrupt_zero), .timer_two_request(timer_two_request),
    .timer_three_request(timer_three_request), .serial_iface_one_done(serial_iface_one_done),
    .converter_one_done(converter_one_done), .other_requests(other_requests),
    .transfer_done(transfer_done), .transfer_start(transfer_start),
    .transfer_forced(transfer_forced));
  dmars_engine_model engine (.pclk(pclk), .presetn(presetn), .transfer_start(transfer_start),
    .lag(lag), .transfer_done(transfer_done));
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Request held until pready is seen high; read data taken at that same edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    err = pslverr;
    rd  = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  function automatic logic [31:0] sel_word(input logic f, input logic [7:0] s);
    return {16'h0, f, 7'h0, s};
  endfunction
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge pclk);
    bad_count++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h239DD97F));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0, "select after reset");
    apb(1'b1, 12'h000, 32'hFFFF7F5A);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, sel_word(1'b0, 8'h5A), "reserved bits");
    apb(1'b0, 12'h008, 32'h0);
    check({rd[30:0], err}, 32'h1, "unmapped read");
    check(pready, 1'b1, "zero-wait ready");
    @(posedge pclk);
    pstrb <= 4'h1;
    apb(1'b1, 12'h000, 32'h000080A5);
    @(posedge pclk);
    pstrb <= 4'hF;
    apb(1'b0, 12'h000, 32'h0);
    check(rd, sel_word(1'b0, 8'hA5), "lane zero only write");
    $display("register test done");
    lag <= 2'h3;
    apb(1'b1, 12'h000, 32'h00008033);
    check(transfer_start, 1'b1, "forced start");
    apb(1'b1, 12'h000, 32'h00000033);
    check(transfer_forced, 1'b1, "force after zero write");
    @(posedge pclk iff transfer_done);
    @(negedge pclk);
    check(transfer_forced, 1'b0, "force after done");
    repeat (3) @(negedge pclk);
    check(transfer_start, 1'b0, "single forced transfer");
    apb(1'b1, 12'h000, 32'h00008033);
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h3, "status while forced busy");
    @(posedge pclk);
    channel_enable <= 1'b0;
    repeat (2) @(negedge pclk);
    check(transfer_forced, 1'b0, "force after disable");
    @(posedge pclk iff transfer_done);
    channel_enable <= 1'b1;
    @(negedge pclk);
    check(transfer_start, 1'b0, "no start after disable");
    $display("force test done");
    for (int i = 0; i < 6; i++) begin
      code = (i < 5) ? codes[i] : 8'h10 + 8'($urandom_range(239));
      sel5 = (i < 5) ? 5'h01 << i : 5'h00;
      lag <= 2'($urandom_range(3));
      apb(1'b1, 12'h000, {24'h0, code});
      @(posedge pclk);
      named          <= ~sel5;
      other_requests <= ~(256'h1 << code);
      @(negedge pclk);
      check(transfer_start, 1'b0, "unselected lines");
      @(posedge pclk);
      named          <= sel5;
      other_requests <= (i < 5) ? 256'h0 : 256'h1 << code;
      @(negedge pclk);
      check(transfer_start, 1'b1, "selected line");
      @(posedge pclk);
      named          <= 5'h00;
      other_requests <= '0;
      @(posedge pclk iff transfer_done);
    end
    $display("select test done");
    @(posedge pclk);
    clk_en <= 1'b0;
    apb(1'b1, 12'h000, 32'h000080C3);
    check(transfer_start, 1'b0, "start while frozen");
    @(posedge pclk);
    clk_en <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    check(rd, sel_word(1'b0, code), "write ignored while frozen");
    $display("clock enable test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
